// file: hw/mmdc_regs.vh
// Purpose: register map, field positions and constants of the min/max and degauss control
// Assumes: 32-bit wishbone data, register index = byte address / 4
// Notes:   8-bit control registers sit in the low byte, upper bits read zero
`ifndef MMDC_REGS_VH
`define MMDC_REGS_VH

// register indices
`define MMDC_IDX_CTRL1     8'h5b
`define MMDC_IDX_CTRL2     8'h5c
`define MMDC_IDX_CTRL3     8'h5d
`define MMDC_IDX_IRQ_STAT  8'h70
`define MMDC_IDX_IRQ_MASK  8'h71
`define MMDC_IDX_MAX_X     8'h72
`define MMDC_IDX_MIN_X     8'h75

// mag_control_one fields
`define MMDC_C1_ACAL       7
`define MMDC_C1_MANUAL     6
// mag_control_two fields
`define MMDC_C2_AUTOINC    5
`define MMDC_C2_DIS        4
`define MMDC_C2_DIS_THS    3
`define MMDC_C2_CLR        2
`define MMDC_C2_CNT_HI     1
`define MMDC_C2_CNT_LO     0
// mag_control_three fields
`define MMDC_C3_RAW        7
`define MMDC_C3_OSR_HI     6
`define MMDC_C3_OSR_LO     4
`define MMDC_C3_THS_UPD    3
`define MMDC_C3_WMASK      8'hf8

// interrupt status bits
`define MMDC_IRQ_DEGAUSS   0
`define MMDC_IRQ_CLEARED   1
`define MMDC_IRQ_STOPPED   2
`define MMDC_IRQ_W         3

// degauss interval codes and periods
`define MMDC_RST_EVERY     2'h0
`define MMDC_RST_16        2'h1
`define MMDC_RST_512       2'h2
`define MMDC_RST_OFF       2'h3
`define MMDC_MASK_16       9'h00f
`define MMDC_MASK_512      9'h1ff

// full-scale reload values
`define MMDC_MIN_INIT      16'h7fff
`define MMDC_MAX_INIT      16'h8000

`define MMDC_REG_RESET     8'h00
`endif

// file: hw/mmdc_degauss_sched.v
// Purpose: schedules magnetic sensor resets in output-rate cycles
// Assumes: rateStart is a one-cycle pulse at each cycle start
// Notes:   trigger inputs are one-cycle pulses
`default_nettype none
`include "mmdc_regs.vh"
module mmdc_degauss_sched (
    // clocking
    input  wire       clock,
    input  wire       rst_b,
    input  wire       ce,
    // control
    input  wire [1:0] interval,
    input  wire       rateStart,
    input  wire       standbyToActive,
    input  wire       manualTrigger,
    // result
    output reg        degaussPulse
);
    reg  [8:0] cycleCount_reg;
    reg        periodic;

    always @* begin
        case (interval)
            `MMDC_RST_EVERY: periodic = 1'b1;
            `MMDC_RST_16:    periodic = (cycleCount_reg & `MMDC_MASK_16) == 9'h000;
            `MMDC_RST_512:   periodic = (cycleCount_reg & `MMDC_MASK_512) == 9'h000;
            default:         periodic = 1'b0;
        endcase
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cycleCount_reg <= 9'h000;
            degaussPulse   <= 1'b0;
        end else if (ce) begin
            if (rateStart) begin
                cycleCount_reg <= cycleCount_reg + 9'h001;
            end
            // standby exit and manual request act in every interval mode
            degaussPulse <= (rateStart & periodic) | standbyToActive | manualTrigger;
        end
    end
endmodule
`default_nettype wire

// file: hw/mmdc_extreme_tracker.v
// Purpose: per-axis running maximum and minimum of magnetic samples
// Assumes: samples are signed 16-bit, packed x in low bits
// Notes:   extremes commit once per output-rate cycle
`default_nettype none
`include "mmdc_regs.vh"
module mmdc_extreme_tracker (
    // clocking
    input  wire        clock,
    input  wire        rst_b,
    input  wire        ce,
    // control
    input  wire        trackEnable,
    input  wire        clearReq,
    input  wire        rateEnd,
    // samples
    input  wire        sampleValid,
    input  wire [47:0] sampleXyz,
    // extremes
    output wire [47:0] maxXyz,
    output wire [47:0] minXyz,
    output reg         clearDone
);
    genvar a;
    generate
        for (a = 0; a < 3; a = a + 1) begin : axis
            reg  signed [15:0] max_reg;
            reg  signed [15:0] min_reg;
            reg  signed [15:0] cycMax_reg;
            reg  signed [15:0] cycMin_reg;
            wire signed [15:0] s = sampleXyz[16*a+15:16*a];
            wire signed [15:0] hi = (sampleValid && s > cycMax_reg) ? s : cycMax_reg;
            wire signed [15:0] lo = (sampleValid && s < cycMin_reg) ? s : cycMin_reg;
            assign maxXyz[16*a+15:16*a] = max_reg;
            assign minXyz[16*a+15:16*a] = min_reg;
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    max_reg    <= `MMDC_MAX_INIT;
                    min_reg    <= `MMDC_MIN_INIT;
                    cycMax_reg <= `MMDC_MAX_INIT;
                    cycMin_reg <= `MMDC_MIN_INIT;
                end else if (ce) begin
                    if (clearReq) begin
                        // clear wins over a same-cycle commit
                        max_reg    <= `MMDC_MAX_INIT;
                        min_reg    <= `MMDC_MIN_INIT;
                        cycMax_reg <= `MMDC_MAX_INIT;
                        cycMin_reg <= `MMDC_MIN_INIT;
                    end else if (rateEnd) begin
                        if (trackEnable) begin
                            max_reg <= (hi > max_reg) ? hi : max_reg;
                            min_reg <= (lo < min_reg) ? lo : min_reg;
                        end
                        cycMax_reg <= `MMDC_MAX_INIT;
                        cycMin_reg <= `MMDC_MIN_INIT;
                    end else begin
                        cycMax_reg <= hi;
                        cycMin_reg <= lo;
                    end
                end
            end
        end
    endgenerate

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            clearDone <= 1'b0;
        end else if (ce) begin
            clearDone <= clearReq & ~clearDone;
        end
    end
endmodule
`default_nettype wire

// file: hw/mmdc_top.v
// Purpose: magnetometer min/max tracking, degauss scheduling and control registers
// Assumes: one clock, wishbone classic slave, sensor events as one-cycle pulses
// Notes:   all outputs registered; ce low freezes every flip-flop
//
// The Wishbone interface to the registers was decided locally.
`default_nettype none
`include "mmdc_regs.vh"
// Functional notes
// - while enabled, commit per-axis max/min at the end of every output-rate cycle.
// - tracked extremes feed auto-calibration to derive hard-iron offsets when enabled.
// - stop-on-threshold set means a threshold event disables min/max tracking.
// - stop-on-threshold clear means threshold events leave tracking alone.
// - clear bit loads minimums with 0x7fff and maximums with 0x8000.
// - clear bit returns to zero by itself after the reload completes.
// - interval 00 resets the sensor at each output-rate cycle start.
// - interval 01 resets the sensor every 16 output-rate cycles.
// - interval 10 resets the sensor every 512 output-rate cycles.
// - interval 11 stops periodic resets; only standby exit or manual bit reset.
// - third control register: raw, sleep oversample, threshold update select, reserved.
// - tracking disable bit: 0 tracks (default), 1 stops tracking.
// - raw set bypasses hard-iron offsets; raw clear applies them.
// - update select 1 refreshes only triggering axis; 0 refreshes all three.
// - sleep oversample field picks the ratio used during auto-sleep.
module mmdc_top (
    // clocking
    input  wire        clock,
    input  wire        rst_b,
    input  wire        ce,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [9:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // sensor side
    input  wire        rateStart,
    input  wire        rateEnd,
    input  wire        sampleValid,
    input  wire [47:0] sampleXyz,
    input  wire        thsEvent,
    input  wire [2:0]  thsAxis,
    input  wire        standbyToActive,
    input  wire        autoSleep,
    input  wire [2:0]  activeOsr,
    // results
    output reg  [47:0] magOutXyz,
    output reg  [47:0] hardIronXyz,
    output reg  [2:0]  refUpdateMask,
    output reg  [2:0]  osrSelect,
    output wire        degaussPulse,
    output reg         irq
);
    reg  [7:0]  ctrl1_reg;
    reg  [7:0]  ctrl2_reg;
    reg  [7:0]  ctrl3_reg;
    reg  [2:0]  irqStat_reg;
    reg  [2:0]  irqMask_reg;
    reg  [7:0]  ctrl1_next;
    reg  [7:0]  ctrl2_next;
    reg  [7:0]  ctrl3_next;
    reg  [2:0]  irqStat_next;
    reg  [31:0] rdData;
    wire [47:0] maxXyz;
    wire [47:0] minXyz;
    wire        clearDone;
    wire        manualDegauss = ctrl1_reg[`MMDC_C1_MANUAL];
    wire [7:0]  idx = wb_adr_i[9:2];
    wire        wrStrobe = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    wire        thsStop = thsEvent & ctrl2_reg[`MMDC_C2_DIS_THS];
    wire [2:0]  events;

    mmdc_extreme_tracker tracker (
        .clock       (clock),
        .rst_b       (rst_b),
        .ce          (ce),
        .trackEnable (~ctrl2_reg[`MMDC_C2_DIS]),
        .clearReq    (ctrl2_reg[`MMDC_C2_CLR]),
        .rateEnd     (rateEnd),
        .sampleValid (sampleValid),
        .sampleXyz   (sampleXyz),
        .maxXyz      (maxXyz),
        .minXyz      (minXyz),
        .clearDone   (clearDone)
    );

    mmdc_degauss_sched sched (
        .clock           (clock),
        .rst_b           (rst_b),
        .ce              (ce),
        .interval        (ctrl2_reg[`MMDC_C2_CNT_HI:`MMDC_C2_CNT_LO]),
        .rateStart       (rateStart),
        .standbyToActive (standbyToActive),
        .manualTrigger   (manualDegauss),
        .degaussPulse    (degaussPulse)
    );

    assign events = {thsStop & ~ctrl2_reg[`MMDC_C2_DIS], clearDone, degaussPulse};

    // register writes; hardware sets and self-clears take priority
    always @* begin
        ctrl1_next   = ctrl1_reg;
        ctrl2_next   = ctrl2_reg;
        ctrl3_next   = ctrl3_reg;
        irqStat_next = irqStat_reg;
        if (wrStrobe) begin
            case (idx)
                `MMDC_IDX_CTRL1:    ctrl1_next = wb_dat_i[7:0];
                `MMDC_IDX_CTRL2:    ctrl2_next = wb_dat_i[7:0];
                `MMDC_IDX_CTRL3:    ctrl3_next = wb_dat_i[7:0] & `MMDC_C3_WMASK;
                `MMDC_IDX_IRQ_STAT: irqStat_next = irqStat_reg & ~wb_dat_i[2:0];
                default:            ctrl1_next = ctrl1_reg;
            endcase
        end
        // manual degauss is a one-shot request
        if (manualDegauss) begin
            ctrl1_next[`MMDC_C1_MANUAL] = 1'b0;
        end
        if (clearDone) begin
            ctrl2_next[`MMDC_C2_CLR] = 1'b0;
        end
        if (thsStop) begin
            ctrl2_next[`MMDC_C2_DIS] = 1'b1;
        end
        irqStat_next = irqStat_next | events;
    end

    always @* begin
        case (idx)
            `MMDC_IDX_CTRL1:        rdData = {24'h000000, ctrl1_reg};
            `MMDC_IDX_CTRL2:        rdData = {24'h000000, ctrl2_reg};
            `MMDC_IDX_CTRL3:        rdData = {24'h000000, ctrl3_reg};
            `MMDC_IDX_IRQ_STAT:     rdData = {29'h0, irqStat_reg};
            `MMDC_IDX_IRQ_MASK:     rdData = {29'h0, irqMask_reg};
            `MMDC_IDX_MAX_X:        rdData = {16'h0000, maxXyz[15:0]};
            `MMDC_IDX_MAX_X + 8'h01: rdData = {16'h0000, maxXyz[31:16]};
            `MMDC_IDX_MAX_X + 8'h02: rdData = {16'h0000, maxXyz[47:32]};
            `MMDC_IDX_MIN_X:        rdData = {16'h0000, minXyz[15:0]};
            `MMDC_IDX_MIN_X + 8'h01: rdData = {16'h0000, minXyz[31:16]};
            `MMDC_IDX_MIN_X + 8'h02: rdData = {16'h0000, minXyz[47:32]};
            default:                rdData = 32'h00000000;
        endcase
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl1_reg   <= `MMDC_REG_RESET;
            ctrl2_reg   <= `MMDC_REG_RESET;
            ctrl3_reg   <= `MMDC_REG_RESET;
            irqStat_reg <= 3'h0;
            irqMask_reg <= 3'h0;
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h00000000;
            irq         <= 1'b0;
        end else if (ce) begin
            ctrl1_reg   <= ctrl1_next;
            ctrl2_reg   <= ctrl2_next;
            ctrl3_reg   <= ctrl3_next;
            irqStat_reg <= irqStat_next;
            if (wrStrobe && idx == `MMDC_IDX_IRQ_MASK) begin
                irqMask_reg <= wb_dat_i[2:0];
            end
            // every address answers; unmapped reads return zero
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            // data stands only in the ack cycle, never after it
            wb_dat_o <= (wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o) ? rdData : 32'h00000000;
            irq      <= |(irqStat_reg & irqMask_reg);
        end
    end

    // offsets, corrected output and threshold reference selection
    genvar a;
    generate
        for (a = 0; a < 3; a = a + 1) begin : axis
            wire signed [16:0] sum = {maxXyz[16*a+15], maxXyz[16*a+15:16*a]}
                                   + {minXyz[16*a+15], minXyz[16*a+15:16*a]};
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    hardIronXyz[16*a+15:16*a] <= 16'h0000;
                    magOutXyz[16*a+15:16*a]   <= 16'h0000;
                end else if (ce) begin
                    // midpoint of the extremes is the hard-iron estimate
                    if (rateEnd && ctrl1_reg[`MMDC_C1_ACAL]) begin
                        hardIronXyz[16*a+15:16*a] <= sum[16:1];
                    end
                    if (sampleValid) begin
                        magOutXyz[16*a+15:16*a] <= ctrl3_reg[`MMDC_C3_RAW] ? sampleXyz[16*a+15:16*a]
                            : sampleXyz[16*a+15:16*a] - hardIronXyz[16*a+15:16*a];
                    end
                end
            end
        end
    endgenerate

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            refUpdateMask <= 3'h0;
            osrSelect     <= 3'h0;
        end else if (ce) begin
            if (thsEvent) begin
                refUpdateMask <= ctrl3_reg[`MMDC_C3_THS_UPD] ? thsAxis : 3'h7;
            end else begin
                refUpdateMask <= 3'h0;
            end
            osrSelect <= autoSleep ? ctrl3_reg[`MMDC_C3_OSR_HI:`MMDC_C3_OSR_LO] : activeOsr;
        end
    end
endmodule
`default_nettype wire

// file: testbench/mmdc_top_asserts.sv
// Purpose: port-level checks of min/max and degauss control
// Assumes: one clock, reset active low
// Notes:   bound to every mmdc_top instance
`default_nettype none
module mmdc_top_asserts (
    // clocking
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        ce,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // sensor
    input wire logic        rateStart,
    input wire logic        rateEnd,
    input wire logic        sampleValid,
    input wire logic        thsEvent,
    input wire logic [2:0]  thsAxis,
    input wire logic        standbyToActive,
    input wire logic        autoSleep,
    input wire logic [2:0]  activeOsr,
    // results
    input wire logic [47:0] magOutXyz,
    input wire logic [47:0] hardIronXyz,
    input wire logic [2:0]  refUpdateMask,
    input wire logic [2:0]  osrSelect,
    input wire logic        degaussPulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // release edge still holds outputs in reset, hence the past rst_b guards
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
        else $error("bus request not answered");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    osr_active_a: assert property ($past(rst_b) && $past(ce) && !$past(autoSleep) |->
        osrSelect == $past(activeOsr)) else $error("osr select wrong while awake");
    ref_idle_a: assert property ($past(rst_b) && $past(ce) && !$past(thsEvent) |-> refUpdateMask == 3'h0)
        else $error("reference update without event");
    ref_axis_a: assert property ($past(rst_b) && $past(ce) && $past(thsEvent) |->
        refUpdateMask == $past(thsAxis) || refUpdateMask == 3'h7) else $error("reference update mask wrong");
    mag_hold_a: assert property ($past(rst_b) && !$past(sampleValid) |-> $stable(magOutXyz))
        else $error("output moved without sample");
    offset_commit_a: assert property (!$stable(hardIronXyz) |-> $past(rateEnd))
        else $error("offset moved outside cycle end");
    degauss_cause_a: assert property (degaussPulse |-> $past(rateStart) || $past(standbyToActive) ||
        $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("degauss without cause");
endmodule
bind mmdc_top mmdc_top_asserts u_chk (.clock, .rst_b, .ce, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .rateStart, .rateEnd, .sampleValid, .thsEvent, .thsAxis, .standbyToActive, .autoSleep, .activeOsr,
    .magOutXyz, .hardIronXyz, .refUpdateMask, .osrSelect, .degaussPulse);
`default_nettype wire

// file: testbench/mmdc_rate_model.sv
// Purpose: sensor front end pacing output-rate cycles
// Assumes: run is a level from the bench
// Notes:   short period keeps the 512-cycle span cheap
`default_nettype none
module mmdc_rate_model #(
    parameter int PERIOD = 8
) (
    // clocking
    input  wire logic clock,
    input  wire logic rst_b,
    // control
    input  wire logic run,
    // rate pulses
    output var logic  rateStart,
    output var logic  rateEnd
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b || !run) begin
            cnt <= 0;
            rateStart <= 1'b0;
            rateEnd <= 1'b0;
        end else begin
            rateStart <= (cnt == 0);
            rateEnd <= (cnt == PERIOD - 1);
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        end
    end
endmodule
`default_nettype wire

// file: testbench/mmdc_top_tb.sv
// Purpose: register-level tests of min/max and degauss control
// Assumes: classic wishbone, one request at a time
// Notes:   y and z samples stay zero
`default_nettype none
module mmdc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, ack, run = 0, rs, re, tbEnd = 0;
    logic sv = 0, ths = 0, stby = 0, aslp = 0, irq, dg;
    logic [9:0]  adr = 0;
    logic [31:0] wdat = 0, rdat, q;
    logic [47:0] sxyz = 0, magOut, hardIron;
    logic [2:0]  axis = 0, refMask, osr;
    int badCount = 0, cmpCount = 0, nStart = 0, nPulse = 0, p;
    always #5 clock = ~clock;
    mmdc_rate_model pace (.clock, .rst_b, .run, .rateStart(rs), .rateEnd(re));
    mmdc_top dut (.clock, .rst_b, .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rateStart(rs),
        .rateEnd(re | tbEnd), .sampleValid(sv), .sampleXyz(sxyz), .thsEvent(ths), .thsAxis(axis),
        .standbyToActive(stby), .autoSleep(aslp), .activeOsr(3'h2), .magOutXyz(magOut),
        .hardIronXyz(hardIron), .refUpdateMask(refMask), .osrSelect(osr), .degaussPulse(dg), .irq);
    always @(posedge clock) begin
        if (rs === 1'b1) nStart++;
        if (dg === 1'b1) nPulse++;
    end
    task testDone;
        if (badCount == 0 && cmpCount > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmpCount++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            badCount++;
        end
    endtask
    task acc(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clock);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        do @(posedge clock); while (ack !== 1'b1);
        q = rdat;
        cyc <= 0;
        stb <= 0;
    endtask
    task wr(input logic [7:0] idx, input logic [31:0] d);
        acc(1'b1, idx, d);
    endtask
    task rd(input logic [7:0] idx, input logic [31:0] e);
        acc(1'b0, idx, 32'h0);
        chk($sformatf("reg %h", idx), e, q);
    endtask
    task smp(input logic [15:0] x);
        @(posedge clock) begin sv <= 1; sxyz <= {32'h0, x}; end
        @(posedge clock) sv <= 0;
    endtask
    task endp;
        @(posedge clock) tbEnd <= 1;
        @(posedge clock) tbEnd <= 0;
    endtask
    task thsHit(input logic [2:0] a, input logic [2:0] e);
        @(posedge clock) begin ths <= 1; axis <= a; end
        @(posedge clock) ths <= 0;
        #1 chk("ref mask", {29'h0, e}, {29'h0, refMask});
    endtask
    task degauss(input logic [1:0] code, input int n, input int e);
        int s0;
        int p0;
        wr(8'h5c, {30'h0, code});
        s0 = nStart;
        p0 = nPulse;
        @(posedge clock) run <= 1;
        wait (nStart - s0 == n);
        @(posedge clock) run <= 0;
        repeat (3) @(posedge clock);
        chk("degauss count", e, nPulse - p0);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        badCount++;
        testDone;
    end
    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1;
        rd(8'h5d, 32'h0);
        rd(8'h5c, 32'h0);
        rd(8'h75, 32'h7fff);
        wr(8'h5d, 32'hff);
        rd(8'h5d, 32'hf8);
        rd(8'h40, 32'h0);
        wr(8'h5d, 32'h0);
        smp(16'h0064);
        smp(16'hffce);
        endp;
        rd(8'h72, 32'h0064);
        rd(8'h75, 32'hffce);
        wr(8'h5b, 32'h80);
        endp;
        #1 chk("hard iron", 32'h19, hardIron[31:0]);
        smp(16'h0064);
        #1 chk("mag out", 32'h4b, {16'h0, magOut[15:0]});
        wr(8'h5d, 32'h80);
        smp(16'h0064);
        #1 chk("mag raw", 32'h64, {16'h0, magOut[15:0]});
        wr(8'h5c, 32'h10);
        smp(16'h01f4);
        endp;
        rd(8'h72, 32'h0064);
        wr(8'h71, 32'h2);
        smp(16'h01f4);
        // cycle end lands on the last reload edge of the clear
        fork
            wr(8'h5c, 32'h4);
            begin
                repeat (3) @(posedge clock);
                tbEnd <= 1;
                @(posedge clock) tbEnd <= 0;
            end
        join
        rd(8'h5c, 32'h0);
        rd(8'h75, 32'h7fff);
        rd(8'h72, 32'h8000);
        chk("irq", 32'h1, {31'h0, irq});
        wr(8'h70, 32'h7);
        repeat (2) @(posedge clock);
        chk("irq", 32'h0, {31'h0, irq});
        smp(16'h0032);
        endp;
        rd(8'h72, 32'h0032);
        wr(8'h5c, 32'h08);
        thsHit(3'h2, 3'h7);
        rd(8'h5c, 32'h18);
        wr(8'h5c, 32'h0);
        wr(8'h5d, 32'h08);
        thsHit(3'h2, 3'h2);
        rd(8'h5c, 32'h0);
        aslp <= 1;
        wr(8'h5d, 32'h50);
        @(posedge clock) #1 chk("osr", 32'h5, {29'h0, osr});
        @(posedge clock) aslp <= 0;
        degauss(2'h0, 32, 32);
        degauss(2'h1, 32, 2);
        degauss(2'h2, 512, 1);
        degauss(2'h3, 16, 0);
        p = nPulse;
        @(posedge clock) stby <= 1;
        @(posedge clock) stby <= 0;
        wr(8'h5b, 32'h40);
        repeat (4) @(posedge clock);
        chk("wake and manual", p + 2, nPulse);
        testDone;
    end
endmodule
`default_nettype wire
